// *** bench/tdof_ctrl_model.sv ***
`timescale 1ns/100ps
// ----------
// Controller model: one 258-bit frame per request.
// ----------
module tdof_ctrl_model (
  // Bit clock from the codec side.
  input wire logic link_bit_clock,
  // Request from the bench.
  input wire logic req,
  input wire logic [257:0] frame_bits,
  output logic busy,
  // Lines towards the decoder.
  output logic link_frame_marker,
  output logic controller_to_codec_serial
);
  logic [257:0] shift_reg; // Bits still to send, MSB first.
  logic [8:0] cnt_reg; // Bits left in the frame.
  assign busy = (cnt_reg != 9'h000);
  initial begin
    shift_reg = '0;
    cnt_reg = 9'h000;
    link_frame_marker = 1'b0;
    controller_to_codec_serial = 1'b0;
  end
  // Lines change on the rising edge so they are settled at the falling one.
  always @(posedge link_bit_clock) begin
    if (busy) begin
      controller_to_codec_serial <= shift_reg[257];
      link_frame_marker <= (cnt_reg > 9'h0F0);
      shift_reg <= {shift_reg[256:0], 1'b0};
      cnt_reg <= cnt_reg - 9'h001;
    end else begin
      // One idle bit keeps the marker low, so the next rise is seen.
      controller_to_codec_serial <= 1'b0;
      link_frame_marker <= 1'b0;
      if (req) begin
        shift_reg <= frame_bits;
        cnt_reg <= 9'h102;
      end
    end
  end
endmodule : tdof_ctrl_model

// *** bench/tdof_decoder_properties.sv ***
`timescale 1ns/100ps
// ----------
// Output checks
// ----------
module tdof_decoder_properties
  import tdof_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // System side.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Link side.
  input wire logic link_bit_clock,
  input wire logic link_frame_marker,
  input wire logic controller_to_codec_serial,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Decoded outputs.
  input wire logic cmd_valid,
  input wire tdof_cmd_t cmd,
  input wire logic sample_valid,
  input wire tdof_sample_t sample
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A frame lasts hundreds of cycles, so two pulses close together mean a double decode.
  property p_cmd_pulse;
    cmd_valid |=> (!cmd_valid) [*8];
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse repeated");
  property p_cmd_hold;
    !cmd_valid |-> $stable(cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved without pulse");
  property p_rd_zero;
    cmd_valid && cmd.rd |-> cmd.data == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read command carries data");
  property p_smp_pulse;
    sample_valid |=> (!sample_valid) [*8];
  endproperty
  a_smp_pulse: assert property (p_smp_pulse) else $error("sample pulse repeated");
  property p_smp_hold;
    !sample_valid |-> $stable(sample);
  endproperty
  a_smp_hold: assert property (p_smp_hold) else $error("sample moved without pulse");
  property p_left_off;
    sample_valid && !sample.left_valid |-> sample.left == 16'h0000;
  endproperty
  a_left_off: assert property (p_left_off) else $error("invalid left not zero");
  property p_right_off;
    sample_valid && !sample.right_valid |-> sample.right == 16'h0000;
  endproperty
  a_right_off: assert property (p_right_off) else $error("invalid right not zero");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_status_w;
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[DATA_W-1:2] == '0;
  endproperty
  a_status_w: assert property (p_status_w) else $error("status upper bits set");
  c_write: cover property (cmd_valid && !cmd.rd);
  c_read: cover property (cmd_valid && cmd.rd);
  c_one_chan: cover property (sample_valid && !sample.right_valid);
endmodule : tdof_decoder_properties

bind tdof_decoder tdof_decoder_properties #(.DATA_W(DATA_W)) i_tdof_decoder_properties (
  .sys_clk(sys_clk), .rst_b(rst_b), .link_bit_clock(link_bit_clock),
  .link_frame_marker(link_frame_marker),
  .controller_to_codec_serial(controller_to_codec_serial), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cmd_valid(cmd_valid), .cmd(cmd), .sample_valid(sample_valid), .sample(sample)
);

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import tdof_pkg::*;
  logic sys_clk, rst_b, link_clk, marker, serial, req, busy, reg_wr, reg_rd;
  logic cmd_valid, sample_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [257:0] frame_bits;
  tdof_cmd_t cmd;
  tdof_sample_t sample;
  int fail_count = 0; // Mismatches.
  int total_checks = 0; // Comparisons.
  int cycles = 0; // Hang limit counter.
  int n_cmd = 0; // Command pulses seen.
  int n_smp = 0; // Sample pulses seen.
  tdof_decoder #(.DATA_W(32)) i_tdof_decoder (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_bit_clock(link_clk),
    .link_frame_marker(marker), .controller_to_codec_serial(serial),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .sample_valid(sample_valid), .sample(sample)
  );
  tdof_ctrl_model i_tdof_ctrl_model (
    .link_bit_clock(link_clk), .req(req), .frame_bits(frame_bits), .busy(busy),
    .link_frame_marker(marker), .controller_to_codec_serial(serial)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Offset so link edges never coincide with system edges.
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Pulse counters; the run needs about 2900 cycles, so 8000 means a hang.
  always @(posedge sys_clk) begin
    cycles++;
    if (cmd_valid === 1'b1) n_cmd++;
    if (sample_valid === 1'b1) n_smp++;
    if (cycles == 8000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge sys_clk);
  endtask : rd_chk
  // Sends a frame, lets it cross, then checks the pulse totals.
  task automatic frame(input logic [15:0] tag, input logic [19:0] s1, s2, s3, s4, s5,
                       input int ec, input int es);
    frame_bits <= {2'b00, tag, s1, s2, s3, s4, s5, 140'h0};
    req <= 1'b1;
    while (busy !== 1'b1) @(posedge sys_clk);
    req <= 1'b0;
    while (busy !== 1'b0) @(posedge sys_clk);
    repeat (12) @(posedge sys_clk);
    check(n_cmd, ec);
    check(n_smp, es);
  endtask : frame
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    req = 1'b0;
    frame_bits = '0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("Test reset done");
    frame(16'hF800, 20'h25000, 20'hBEEF0, 20'h12340, 20'hABCD0, 20'h0, 1, 1);
    check(cmd, {1'b0, 6'h12, 16'hBEEF});
    check(sample, {2'b11, 16'h1234, 16'hABCD});
    rd_chk(8'h08, 32'hF800);
    rd_chk(8'h10, {9'h0, 1'b0, 6'h12, 16'hBEEF});
    rd_chk(8'h04, 32'h2);
    $display("Test write done");
    frame(16'hC000, 20'h90000, 20'h0, 20'h0, 20'h0, 20'h0, 2, 1);
    check(cmd, {1'b1, 6'h08, 16'h0});
    $display("Test read done");
    frame(16'h7800, 20'h25000, 20'h11110, 20'h12340, 20'hABCD0, 20'h0, 2, 1);
    frame(16'hC000, 20'h26000, 20'h0, 20'h0, 20'h0, 20'h0, 2, 1);
    frame(16'h9000, 20'h0, 20'h0, 20'h55550, 20'h0, 20'h0, 2, 2);
    check(sample, {2'b10, 16'h5555, 16'h0});
    $display("Test gating done");
    frame(16'h8800, 20'h0, 20'h0, 20'h0, 20'h66660, 20'h1, 2, 3);
    check(sample, {2'b01, 16'h0, 16'h6666});
    rd_chk(8'h04, 32'h3);
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h2);
    $display("Test padding done");
    wr(8'h00, 32'h0);
    rd_chk(8'h00, 32'h0);
    frame(16'hF800, 20'h25000, 20'hBEEF0, 20'h12340, 20'hABCD0, 20'h0, 2, 3);
    rd_chk(8'h0C, 32'h7);
    wr(8'h00, 32'h1);
    $display("Test disable done");
    close_out();
  end
endmodule : testbench

// *** core/tdof_decoder.sv ***
// Overview of operation
// - Sample marker and serial data on falling edges.
// - Twelve twenty-bit slots follow, MSB first.
// - Tag bit 15 gates the whole frame.
// - Tag bit 14 validates slot one.
// - Slot one bit 19 selects read or write.
// - Slot one bits 18..13 give the even register index.
// - Slot two bits 19..4 hold write data.
// - Slots three, four carry left, right samples.
// - Slots five to twelve are reserved, zero.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`include "tdof_consts.svh"

module tdof_decoder
  import tdof_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Link side, clocked by the bit clock.
  input wire logic link_bit_clock,
  input wire logic link_frame_marker,
  input wire logic controller_to_codec_serial,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Decoded command towards the control registers.
  output logic cmd_valid,
  output tdof_cmd_t cmd,
  // Decoded playback samples.
  output logic sample_valid,
  output tdof_sample_t sample
);

  // --------------------------------------------------------------------------
  // Link domain: frame position tracking
  // --------------------------------------------------------------------------
  logic mark_prev_reg; // Marker as seen at the previous falling edge.
  logic [19:0] shift_reg; // Last twenty serial bits, newest at bit 0.
  logic [3:0] slot_reg; // Slot of the next bit; idle after the last slot.
  logic [4:0] bit_reg; // Bit position inside that slot.
  logic [15:0] tag_reg; // Tag of the frame in progress.
  logic en_link_reg; // Decode enable after crossing into the link domain.

  logic frame_start;
  logic [3:0] cur_slot;
  logic [4:0] cur_bit;
  logic [19:0] word;
  logic slot_end;

  // A rising marker restarts the frame even mid-frame, so a slipped
  // controller is followed at once instead of after a timeout.
  assign frame_start = link_frame_marker && !mark_prev_reg;
  assign cur_slot = frame_start ? `TDOF_SLOT_TAG : slot_reg;
  assign cur_bit = frame_start ? 5'h00 : bit_reg;
  assign word = {shift_reg[18:0], controller_to_codec_serial};

  // The tag phase ends after its own length, each data slot after twenty bits.
  always_comb begin
    if (cur_slot == `TDOF_SLOT_TAG) begin
      slot_end = (cur_bit == 5'(`TDOF_TAG_BITS - 1));
    end else if (cur_slot <= `TDOF_SLOT_LAST) begin
      slot_end = (cur_bit == 5'(`TDOF_SLOT_BITS - 1));
    end else begin
      slot_end = 1'b0;
    end
  end

  // Capture on the falling bit clock edge, when the controller's data is
  // stable half a period after it changed on the rising edge.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      mark_prev_reg <= 1'b0;
      shift_reg <= 20'h00000;
    end else begin
      mark_prev_reg <= link_frame_marker;
      shift_reg <= word;
    end
  end

  // Slot and bit counters; they park in the idle slot until the next marker.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      slot_reg <= `TDOF_SLOT_IDLE;
      bit_reg <= 5'h00;
    end else if (slot_end) begin
      slot_reg <= cur_slot + 4'h1;
      bit_reg <= 5'h00;
    end else if (cur_slot != `TDOF_SLOT_IDLE) begin
      slot_reg <= cur_slot;
      bit_reg <= cur_bit + 5'h01;
    end
  end

  // Tag is the low sixteen bits of the tag phase.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      tag_reg <= 16'h0000;
    end else if (slot_end && cur_slot == `TDOF_SLOT_TAG) begin
      tag_reg <= word[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: slot validity and padding checks
  // --------------------------------------------------------------------------
  logic [`TDOF_NUM_SLOTS:1] slot_ok; // Per-slot valid, gated by frame valid.
  logic cur_ok; // Validity of the slot now ending.
  logic pad_bad; // Slot now ending breaks the zero-padding convention.
  logic cmd_rd_reg;
  logic [5:0] cmd_idx_reg;
  logic cmd_live_reg;

  // Slot n is honoured only with the frame flag, its own flag and enable.
  always_comb begin
    for (int n = 1; n <= `TDOF_NUM_SLOTS; n++) begin
      slot_ok[n] = en_link_reg && tag_reg[`TDOF_TAG_FRAME_VALID]
                   && tag_reg[`TDOF_TAG_FRAME_VALID - n];
    end
  end

  always_comb begin
    cur_ok = 1'b0;
    if (cur_slot >= `TDOF_SLOT_CMD_ADDR && cur_slot <= `TDOF_SLOT_LAST) begin
      cur_ok = slot_ok[cur_slot];
    end
  end

  // Padding violations are only recorded, never acted on; a sloppy controller
  // still gets its valid slots decoded.
  always_comb begin
    pad_bad = 1'b0;
    if (slot_end) begin
      if (cur_slot == `TDOF_SLOT_TAG) begin
        pad_bad = |word[`TDOF_TAG_PAD_HI:0];
      end else if (!cur_ok || cur_slot > `TDOF_SLOT_RIGHT) begin
        pad_bad = |word;
      end else if (cur_slot == `TDOF_SLOT_CMD_ADDR) begin
        pad_bad = |word[`TDOF_CMD_PAD_HI:0];
      end else if (cur_slot == `TDOF_SLOT_CMD_DATA && cmd_rd_reg) begin
        pad_bad = |word;
      end else begin
        pad_bad = |word[`TDOF_DATA_PAD_HI:0];
      end
    end
  end

  // Slot one: direction and even register index.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rd_reg <= 1'b0;
      cmd_idx_reg <= 6'h00;
      cmd_live_reg <= 1'b0;
    end else if (frame_start) begin
      cmd_live_reg <= 1'b0;
    end else if (slot_end && cur_slot == `TDOF_SLOT_CMD_ADDR) begin
      cmd_rd_reg <= word[`TDOF_CMD_RW_BIT];
      cmd_idx_reg <= word[`TDOF_IDX_HI:`TDOF_IDX_EVEN_LO];
      cmd_live_reg <= slot_ok[1];
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: hold words and their toggles
  // --------------------------------------------------------------------------
  // Each hold word is written once and then left alone for at least forty
  // bit times, far longer than the system side needs to take it.
  tdof_cmd_t cmd_hold_reg;
  tdof_sample_t smp_hold_reg;
  tdof_frame_t frm_hold_reg;
  logic [15:0] left_reg;
  logic left_ok_reg;
  logic pad_acc_reg;
  logic tgl_cmd_reg; // Flips once per accepted command.
  logic tgl_smp_reg; // Flips once per accepted sample pair.
  logic tgl_frm_reg; // Flips once per completed frame.
  logic [2:0] tgl_link; // Toggles: 0 command, 1 sample, 2 frame.

  // Each toggle has its own process, so every register keeps a single driver.
  assign tgl_link = {tgl_frm_reg, tgl_smp_reg, tgl_cmd_reg};

  // Slot two completes a command; a write needs slot two valid as well.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_hold_reg <= '0;
      tgl_cmd_reg <= 1'b0;
    end else if (slot_end && cur_slot == `TDOF_SLOT_CMD_DATA && !frame_start
                 && cmd_live_reg && (cmd_rd_reg || slot_ok[2])) begin
      cmd_hold_reg.rd <= cmd_rd_reg;
      cmd_hold_reg.index <= cmd_idx_reg;
      cmd_hold_reg.data <= cmd_rd_reg ? 16'h0000
                           : word[`TDOF_DATA_HI:`TDOF_DATA_LO];
      tgl_cmd_reg <= !tgl_cmd_reg;
    end
  end

  // Slots three and four: samples are taken as sent; short samples are
  // already left-justified by the controller, so no shifting is done here.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      left_reg <= 16'h0000;
      left_ok_reg <= 1'b0;
      smp_hold_reg <= '0;
      tgl_smp_reg <= 1'b0;
    end else if (slot_end && cur_slot == `TDOF_SLOT_LEFT) begin
      left_reg <= slot_ok[3] ? word[`TDOF_DATA_HI:`TDOF_DATA_LO] : 16'h0000;
      left_ok_reg <= slot_ok[3];
    end else if (slot_end && cur_slot == `TDOF_SLOT_RIGHT
                 && (left_ok_reg || slot_ok[4])) begin
      smp_hold_reg.left_valid <= left_ok_reg;
      smp_hold_reg.right_valid <= slot_ok[4];
      smp_hold_reg.left <= left_reg;
      smp_hold_reg.right <= slot_ok[4] ? word[`TDOF_DATA_HI:`TDOF_DATA_LO]
                            : 16'h0000;
      tgl_smp_reg <= !tgl_smp_reg;
    end
  end

  // Frame summary after the last reserved slot.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      pad_acc_reg <= 1'b0;
      frm_hold_reg <= '0;
      tgl_frm_reg <= 1'b0;
    end else if (slot_end && cur_slot == `TDOF_SLOT_TAG) begin
      pad_acc_reg <= pad_bad;
    end else if (slot_end && cur_slot == `TDOF_SLOT_LAST) begin
      frm_hold_reg.tag <= tag_reg;
      frm_hold_reg.pad_err <= pad_acc_reg || pad_bad;
      tgl_frm_reg <= !tgl_frm_reg;
    end else if (pad_bad) begin
      pad_acc_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Enable into the link domain
  // --------------------------------------------------------------------------
  logic ctrl_en_reg;
  logic [2:0] en_sync_reg;

  // Three flops; a change is believed only once the second and third agree.
  always_ff @(negedge link_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      en_sync_reg <= {3{`TDOF_CTRL_RESET}};
      en_link_reg <= `TDOF_CTRL_RESET;
    end else begin
      en_sync_reg <= {en_sync_reg[1:0], ctrl_en_reg};
      if (en_sync_reg[1] == en_sync_reg[2]) begin
        en_link_reg <= en_sync_reg[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // System domain: toggle synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] tgl_event; // One-cycle pulse per accepted toggle.

  for (genvar g = 0; g < 3; g++) begin : g_tgl
    logic [2:0] sync_reg;
    logic seen_reg; // Toggle level already acted upon.

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_reg <= 3'h0;
        seen_reg <= 1'b0;
      end else begin
        sync_reg <= {sync_reg[1:0], tgl_link[g]};
        if (sync_reg[1] == sync_reg[2]) begin
          seen_reg <= sync_reg[2];
        end
      end
    end

    assign tgl_event[g] = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != seen_reg);
  end

  // Decoded outputs are copied out of the stable hold words.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
      sample_valid <= 1'b0;
      sample <= '0;
    end else begin
      cmd_valid <= tgl_event[0];
      sample_valid <= tgl_event[1];
      if (tgl_event[0]) begin
        cmd <= cmd_hold_reg;
      end
      if (tgl_event[1]) begin
        sample <= smp_hold_reg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // System domain: status and control registers
  // --------------------------------------------------------------------------
  logic pad_err_reg; // Sticky padding error, write one to clear.
  logic frame_seen_reg; // At least one frame completed since reset.
  logic [15:0] last_tag_reg;
  logic [DATA_W-1:0] frames_reg; // Count of completed frames.

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_reg <= `TDOF_CTRL_RESET;
    end else if (reg_wr && reg_addr == `TDOF_REG_CTRL) begin
      ctrl_en_reg <= reg_wdata[0];
    end
  end

  // A new error in the same cycle as its clear survives the clear.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_err_reg <= 1'b0;
      frame_seen_reg <= 1'b0;
      last_tag_reg <= 16'h0000;
      frames_reg <= '0;
    end else begin
      if (tgl_event[2] && frm_hold_reg.pad_err) begin
        pad_err_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `TDOF_REG_STATUS
                   && reg_wdata[`TDOF_STAT_PAD_ERR]) begin
        pad_err_reg <= 1'b0;
      end
      if (tgl_event[2]) begin
        frame_seen_reg <= 1'b1;
        last_tag_reg <= frm_hold_reg.tag;
        frames_reg <= frames_reg + 1'b1;
      end
    end
  end

  // Read data stands for the cycle after the strobe only; unmapped reads zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        `TDOF_REG_CTRL: reg_rdata <= DATA_W'(ctrl_en_reg);
        `TDOF_REG_STATUS: reg_rdata <= DATA_W'({frame_seen_reg, pad_err_reg});
        `TDOF_REG_TAG: reg_rdata <= DATA_W'(last_tag_reg);
        `TDOF_REG_FRAMES: reg_rdata <= frames_reg;
        `TDOF_REG_LAST_CMD: reg_rdata <= DATA_W'(cmd);
        default: reg_rdata <= '0;
      endcase
    end
  end

endmodule : tdof_decoder

// *** pkg/tdof_consts.svh ***
`ifndef TDOF_CONSTS_SVH
`define TDOF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------------
`define TDOF_TAG_BITS 18
`define TDOF_SLOT_BITS 20
`define TDOF_NUM_SLOTS 12
`define TDOF_SLOT_TAG 4'h0
`define TDOF_SLOT_CMD_ADDR 4'h1
`define TDOF_SLOT_CMD_DATA 4'h2
`define TDOF_SLOT_LEFT 4'h3
`define TDOF_SLOT_RIGHT 4'h4
`define TDOF_SLOT_LAST 4'hC
`define TDOF_SLOT_IDLE 4'hD

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TDOF_TAG_FRAME_VALID 15
`define TDOF_TAG_PAD_HI 2
`define TDOF_CMD_RW_BIT 19
`define TDOF_IDX_HI 18
`define TDOF_IDX_EVEN_LO 13
`define TDOF_CMD_PAD_HI 11
`define TDOF_DATA_HI 19
`define TDOF_DATA_LO 4
`define TDOF_DATA_PAD_HI 3

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define TDOF_REG_CTRL 8'h00
`define TDOF_REG_STATUS 8'h04
`define TDOF_REG_TAG 8'h08
`define TDOF_REG_FRAMES 8'h0C
`define TDOF_REG_LAST_CMD 8'h10
`define TDOF_CTRL_RESET 1'b1
`define TDOF_STAT_PAD_ERR 0
`define TDOF_STAT_FRAME_SEEN 1

`endif

// *** pkg/tdof_pkg.sv ***
package tdof_pkg;

  // --------------------------------------------------------------------------
  // Decoded register command and playback sample pair.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic [5:0] index;
    logic [15:0] data;
  } tdof_cmd_t;

  typedef struct packed {
    logic left_valid;
    logic right_valid;
    logic [15:0] left;
    logic [15:0] right;
  } tdof_sample_t;

  // Summary of one whole frame: its tag and whether padding was broken.
  typedef struct packed {
    logic pad_err;
    logic [15:0] tag;
  } tdof_frame_t;

endpackage : tdof_pkg
